/* File: design/fbp_pkg.sv */
// Shared constants and types of the frame buffer pixel and palette path.
package fbp_pkg;

  // ****************************************************************
  // Frame buffer geometry
  // ****************************************************************
  localparam int FBP_BANKS      = 4;
  localparam int FBP_BANK_SEL_W = 2;
  localparam int FBP_BANK_W     = 16;
  localparam int FBP_PIX_W      = 4;
  localparam int FBP_PIX_PER_WD = FBP_BANK_W / FBP_PIX_W;
  localparam int FBP_LINE_W     = FBP_BANKS * FBP_BANK_W;
  localparam int FBP_DEPTH      = 65536;
  localparam int FBP_AW         = 16;
  localparam int FBP_DRAW_AW    = FBP_AW + FBP_BANK_SEL_W;

  // ****************************************************************
  // Host palette port
  // ****************************************************************
  localparam int FBP_HOST_W     = 8;
  localparam int FBP_PAL_DATA_LO = 0;
  localparam int FBP_PAL_ADDR_LO = 4;
  localparam int FBP_PAL_CH     = 3;

  // ****************************************************************
  // Values after reset (all write strobes are active low and idle high)
  // ****************************************************************
  localparam logic [FBP_BANKS-1:0]  FBP_WE_IDLE  = 4'hf;
  localparam logic [FBP_PAL_CH-1:0] FBP_PAL_IDLE = 3'h7;
  localparam logic [FBP_PIX_W-1:0]  FBP_PIX_RST  = 4'h0;
  localparam logic [FBP_LINE_W-1:0] FBP_LINE_RST = 64'h0;

  // Colour table address source.
  typedef enum logic {
    FBP_SRC_HOST,
    FBP_SRC_PIXEL
  } fbp_src_t;

  // Progress of the first colour table load.
  typedef enum logic [1:0] {
    FBP_INIT_WAIT,
    FBP_INIT_RUN,
    FBP_INIT_DONE
  } fbp_init_t;

endpackage

/* File: design/fbp_fb_if.sv */
// Connection between the pixel path and its frame buffer memory.
`timescale 1ns/1ps
`default_nettype none
interface fbp_fb_if;
  import fbp_pkg::*;
  logic [FBP_BANKS-1:0]  we_n;
  logic [FBP_AW-1:0]     waddr;
  logic [FBP_BANK_W-1:0] wdata;
  logic                  rd_en;
  logic [FBP_AW-1:0]     raddr;
  logic [FBP_LINE_W-1:0] rdata;

  modport ctl (output we_n, output waddr, output wdata,
               output rd_en, output raddr, input rdata);
  modport mem (input we_n, input waddr, input wdata,
               input rd_en, input raddr, output rdata);
endinterface
`default_nettype wire

/* File: design/fbp_frame_mem.sv */
// Four bank frame buffer with per-bank write strobes and a wide read.
`timescale 1ns/1ps
`default_nettype none
module fbp_frame_mem #(
  parameter int DEPTH = fbp_pkg::FBP_DEPTH
) (
  input  wire logic clk_sys,
  fbp_fb_if.mem     fb
);
  import fbp_pkg::*;

  localparam int MAW = $clog2(DEPTH);

  // Only power-of-two depths map cleanly onto the truncated address.
  if (DEPTH < 2 || DEPTH > (1 << FBP_AW) ||
      (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("fbp_frame_mem: DEPTH out of range");
  end

  logic [FBP_BANK_W-1:0] bank_q [FBP_BANKS][DEPTH];
  logic [FBP_LINE_W-1:0] rdata_q;

  // ****************************************************************
  // Banks: each has its own strobe, so a draw touches one bank only
  // ****************************************************************
  for (genvar b = 0; b < FBP_BANKS; b++) begin : g_bank
    always_ff @(posedge clk_sys) begin
      if (!fb.we_n[b]) begin
        bank_q[b][fb.waddr[MAW-1:0]] <= fb.wdata;
      end
    end

    always_ff @(posedge clk_sys) begin
      if (fb.rd_en) begin
        rdata_q[b*FBP_BANK_W +: FBP_BANK_W] <= bank_q[b][fb.raddr[MAW-1:0]];
      end
    end
  end

  assign fb.rdata = rdata_q;

endmodule
`default_nettype wire

/* File: design/fbp_pixel_path.sv */
// Pixel shifter, colour table address mux, palette strobes and blanking.
//
// Contract
// - Four 16-bit banks, each own write strobe.
// - Bank word holds four 4-bit pixels.
// - Load all pixels of bank words together.
// - Pixel bits leave together as table address.
// - Palette data from host bits 3..0.
// - Host bits 7..4 address table during initialisation.
// - After first initialisation, pixels address the table.
// - Palette write pulses delayed inside stable address.
// - Pixel clock strobes the converter every pixel.
// - Blanking passes two pixel clock flip-flops.
// - White, bright and sync inputs held low.
// - Low address bits pick one bank.
// - Pixel clock shifts, load pulse loads shifter.
`timescale 1ns/1ps
`default_nettype none
module fbp_pixel_path #(
  parameter int DEPTH = fbp_pkg::FBP_DEPTH
) (
  input  wire logic                          clk_sys,
  input  wire logic                          srst,
  input  wire logic                          draw_req,
  input  wire logic                          draw_wr,
  input  wire logic [fbp_pkg::FBP_DRAW_AW-1:0] draw_addr,
  input  wire logic [fbp_pkg::FBP_BANK_W-1:0]  draw_data,
  input  wire logic                          disp_rd,
  input  wire logic [fbp_pkg::FBP_AW-1:0]    disp_addr,
  input  wire logic                          parallel_load,
  input  wire logic                          blank_in,
  input  wire logic [fbp_pkg::FBP_HOST_W-1:0] host_data,
  input  wire logic [fbp_pkg::FBP_PAL_CH-1:0] host_pal_sel_n,
  input  wire logic                          host_init_active,
  output logic [fbp_pkg::FBP_BANKS-1:0]      bank_write_strobes_n,
  output logic [fbp_pkg::FBP_BANKS-1:0]      bank_xcvr_en_n,
  output logic [fbp_pkg::FBP_PIX_W-1:0]      colour_table_addr,
  output logic [fbp_pkg::FBP_PIX_W-1:0]      palette_data,
  output logic                               palette_write_red_n,
  output logic                               palette_write_green_n,
  output logic                               palette_write_blue_n,
  output logic                               dac_strobe,
  output logic                               dac_blank,
  output logic                               dac_white,
  output logic                               dac_bright,
  output logic                               dac_sync,
  output logic                               table_init_done
);
  import fbp_pkg::*;

  if (DEPTH < 2 || DEPTH > (1 << FBP_AW) ||
      (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("fbp_pixel_path: DEPTH out of range");
  end

  // Active-low one-hot bank select from the two low address bits.
  function automatic logic [FBP_BANKS-1:0] bank_sel_n(
    input logic [FBP_BANK_SEL_W-1:0] sel
  );
    logic [FBP_BANKS-1:0] v;
    v = FBP_WE_IDLE;
    v[sel] = 1'b0;
    return v;
  endfunction

  fbp_fb_if fb ();

  fbp_frame_mem #(.DEPTH(DEPTH)) u_mem (
    .clk_sys (clk_sys),
    .fb      (fb)
  );

  // ****************************************************************
  // Drawing cycles
  // ****************************************************************
  logic [FBP_DRAW_AW-1:0] draw_addr_q;
  logic [FBP_BANK_W-1:0]  draw_data_q;
  logic [FBP_BANKS-1:0]   we_n_q;
  logic [FBP_BANKS-1:0]   xcvr_n_q;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      draw_addr_q <= '0;
      draw_data_q <= '0;
    end else if (draw_req) begin
      draw_addr_q <= draw_addr;
      draw_data_q <= draw_data;
    end
  end

  // One bank transceiver and at most one strobe per draw cycle.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      we_n_q   <= FBP_WE_IDLE;
      xcvr_n_q <= FBP_WE_IDLE;
    end else if (draw_req) begin
      xcvr_n_q <= bank_sel_n(draw_addr[FBP_BANK_SEL_W-1:0]);
      we_n_q   <= draw_wr ? bank_sel_n(draw_addr[FBP_BANK_SEL_W-1:0])
                          : FBP_WE_IDLE;
    end else begin
      xcvr_n_q <= FBP_WE_IDLE;
      we_n_q   <= FBP_WE_IDLE;
    end
  end

  assign fb.we_n  = we_n_q;
  assign fb.waddr = draw_addr_q[FBP_DRAW_AW-1:FBP_BANK_SEL_W];
  assign fb.wdata = draw_data_q;
  assign fb.rd_en = disp_rd;
  assign fb.raddr = disp_addr;
  assign bank_write_strobes_n = we_n_q;
  assign bank_xcvr_en_n       = xcvr_n_q;

  // ****************************************************************
  // Pixel shifter
  // ****************************************************************
  // Bank 0 sits in the low 16 bits, so shifting right by one pixel
  // width emits bank 0 bits 3..0 first and bank 3 bits 15..12 last.
  logic [FBP_LINE_W-1:0] line_q;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      line_q <= FBP_LINE_RST;
    end else if (parallel_load) begin
      line_q <= fb.rdata;
    end else begin
      line_q <= {{FBP_PIX_W{1'b0}},
                 line_q[FBP_LINE_W-1:FBP_PIX_W]};
    end
  end

  // ****************************************************************
  // Host palette port synchronisers
  // ****************************************************************
  logic [FBP_HOST_W-1:0] host_data_m_q;
  logic [FBP_HOST_W-1:0] host_data_s_q;
  logic [FBP_PAL_CH-1:0] sel_n_m_q;
  logic [FBP_PAL_CH-1:0] sel_n_s_q;
  logic                  init_m_q;
  logic                  init_s_q;

  // The selects arrive already decoded and qualified by the host clock.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      host_data_m_q <= '0;
      host_data_s_q <= '0;
      sel_n_m_q     <= FBP_PAL_IDLE;
      sel_n_s_q     <= FBP_PAL_IDLE;
      init_m_q      <= 1'b0;
      init_s_q      <= 1'b0;
    end else begin
      host_data_m_q <= host_data;
      host_data_s_q <= host_data_m_q;
      sel_n_m_q     <= host_pal_sel_n;
      sel_n_s_q     <= sel_n_m_q;
      init_m_q      <= host_init_active;
      init_s_q      <= init_m_q;
    end
  end

  // ****************************************************************
  // First colour table load tracking
  // ****************************************************************
  fbp_init_t init_q;
  fbp_src_t  src;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      init_q <= FBP_INIT_WAIT;
    end else begin
      case (init_q)
        FBP_INIT_WAIT: if (init_s_q) init_q <= FBP_INIT_RUN;
        FBP_INIT_RUN:  if (!init_s_q) init_q <= FBP_INIT_DONE;
        default:       init_q <= FBP_INIT_DONE;
      endcase
    end
  end

  assign src = (init_q == FBP_INIT_DONE) ? FBP_SRC_PIXEL : FBP_SRC_HOST;

  // ****************************************************************
  // Colour table address, palette data and write pulses
  // ****************************************************************
  logic [FBP_PIX_W-1:0]  addr_q;
  logic [FBP_PIX_W-1:0]  pdata_q;
  logic [FBP_PAL_CH-1:0] sel_d1_q;
  logic [FBP_PAL_CH-1:0] pal_we_n_q;
  logic                  done_q;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      addr_q <= FBP_PIX_RST;
    end else if (src == FBP_SRC_PIXEL) begin
      addr_q <= line_q[FBP_PIX_W-1:0];
    end else begin
      addr_q <= host_data_s_q[FBP_PAL_ADDR_LO +: FBP_PIX_W];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pdata_q <= FBP_PIX_RST;
    end else begin
      pdata_q <= host_data_s_q[FBP_PAL_DATA_LO +: FBP_PIX_W];
    end
  end

  // The pulse opens one cycle after the select is seen, so the address
  // register has already settled, and it closes with the select.
  // Writes are honoured only while the host owns the address mux.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sel_d1_q   <= '0;
      pal_we_n_q <= FBP_PAL_IDLE;
    end else begin
      sel_d1_q   <= ~sel_n_s_q;
      pal_we_n_q <= (src == FBP_SRC_HOST)
                  ? ~(~sel_n_s_q & sel_d1_q) : FBP_PAL_IDLE;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      done_q <= 1'b0;
    end else begin
      done_q <= (src == FBP_SRC_PIXEL);
    end
  end

  assign colour_table_addr     = addr_q;
  assign palette_data          = pdata_q;
  assign palette_write_red_n   = pal_we_n_q[0];
  assign palette_write_green_n = pal_we_n_q[1];
  assign palette_write_blue_n  = pal_we_n_q[2];
  assign table_init_done       = done_q;

  // ****************************************************************
  // Converter strobe, blanking and unused converter inputs
  // ****************************************************************
  // The strobe stays high so the converter latches one address on
  // every pixel clock edge.
  logic strobe_q;
  logic blank_d1_q;
  logic blank_q;
  logic fixed_low_q;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      strobe_q <= 1'b0;
    end else begin
      strobe_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      blank_d1_q <= 1'b1;
      blank_q    <= 1'b1;
    end else begin
      blank_d1_q <= blank_in;
      blank_q    <= blank_d1_q;
    end
  end

  always_ff @(posedge clk_sys) begin
    fixed_low_q <= 1'b0;
  end

  assign dac_strobe = strobe_q;
  assign dac_blank  = blank_q;
  assign dac_white  = fixed_low_q;
  assign dac_bright = fixed_low_q;
  assign dac_sync   = fixed_low_q;

endmodule
`default_nettype wire

/* File: test/fbp_checker.sv */
// Port assertions for the pixel and palette path.
`timescale 1ns/1ps
`default_nettype none
module fbp_checker
  import fbp_pkg::*;
(
  input wire logic                   clk_sys,
  input wire logic                   srst,
  input wire logic                   draw_req,
  input wire logic                   draw_wr,
  input wire logic [FBP_DRAW_AW-1:0] draw_addr,
  input wire logic                   blank_in,
  input wire logic [FBP_HOST_W-1:0]  host_data,
  input wire logic [FBP_BANKS-1:0]   bank_write_strobes_n,
  input wire logic [FBP_BANKS-1:0]   bank_xcvr_en_n,
  input wire logic [FBP_PIX_W-1:0]   colour_table_addr,
  input wire logic [FBP_PIX_W-1:0]   palette_data,
  input wire logic                   palette_write_red_n,
  input wire logic                   palette_write_green_n,
  input wire logic                   palette_write_blue_n,
  input wire logic                   dac_strobe,
  input wire logic                   dac_blank,
  input wire logic                   dac_white,
  input wire logic                   dac_bright,
  input wire logic                   dac_sync,
  input wire logic                   table_init_done
);
  // ****
  // Helpers
  // ****
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  logic [1:0] up_q;
  logic [2:0] pal_n;
  assign pal_n = {palette_write_blue_n, palette_write_green_n,
                  palette_write_red_n};
  // Counts edges since reset so $past never looks into the reset period.
  always_ff @(posedge clk_sys) begin
    if (srst) up_q <= 2'h0;
    else if (up_q != 2'h3) up_q <= up_q + 2'h1;
  end
  sequence host_settled;
    (up_q == 2'h3 && $stable(host_data)) [*4] ##0 !table_init_done;
  endsequence
  a_one_bank_wr: assert property (draw_req && draw_wr |=>
    bank_write_strobes_n == ~(4'h1 << $past(draw_addr[1:0])))
    else $error("bank write strobe wrong");
  a_one_xcvr: assert property (draw_req |=>
    bank_xcvr_en_n == ~(4'h1 << $past(draw_addr[1:0])))
    else $error("transceiver enable wrong");
  a_host_addr: assert property (host_settled |->
    colour_table_addr == host_data[7:4]) else $error("host address wrong");
  a_host_data: assert property (host_settled |->
    palette_data == host_data[3:0]) else $error("palette data wrong");
  a_write_in_window: assert property (pal_n != FBP_PAL_IDLE |->
    $stable(colour_table_addr) && $stable(palette_data))
    else $error("palette write outside stable address");
  a_no_late_write: assert property (table_init_done |->
    pal_n == FBP_PAL_IDLE) else $error("palette write after init");
  a_done_sticky: assert property (table_init_done |=> table_init_done)
    else $error("init done dropped");
  a_blank_two_ff: assert property (up_q == 2'h3 |->
    dac_blank == $past(blank_in, 2)) else $error("blank delay wrong");
  a_strobe_on: assert property (up_q != 2'h0 |-> dac_strobe)
    else $error("converter strobe low");
  a_unused_low: assert property (
    !(dac_white || dac_bright || dac_sync))
    else $error("unused converter input high");
endmodule
bind fbp_pixel_path fbp_checker u_chk (.*);
`default_nettype wire

/* File: test/fbp_dac_model.sv */
// Behavioural video converter: colour table store and pixel capture.
`timescale 1ns/1ps
`default_nettype none
module fbp_dac_model
  import fbp_pkg::*;
(
  input wire logic                  clk_sys,
  input wire logic [FBP_PIX_W-1:0]  colour_table_addr,
  input wire logic [FBP_PIX_W-1:0]  palette_data,
  input wire logic [FBP_PAL_CH-1:0] pal_wr_n,
  input wire logic                  dac_strobe,
  output logic [FBP_PIX_W-1:0]      pix_q
);
  logic [FBP_PIX_W-1:0] tbl_q [FBP_PAL_CH][16];
  always_ff @(posedge clk_sys) begin
    for (int c = 0; c < FBP_PAL_CH; c++) begin
      if (!pal_wr_n[c]) tbl_q[c][colour_table_addr] <= palette_data;
    end
  end
  // One table address is latched on every pixel clock while enabled.
  always_ff @(posedge clk_sys) begin
    if (dac_strobe) pix_q <= colour_table_addr;
  end
endmodule
`default_nettype wire

/* File: test/fbp_pixel_path_tb.sv */
// Self-checking bench of the pixel path with a converter model.
`timescale 1ns/1ps
`default_nettype none
module fbp_pixel_path_tb;
  import fbp_pkg::*;
  logic        clk_sys = 1'b0;
  logic        srst = 1'b1;
  logic        draw_req, draw_wr, disp_rd, parallel_load, blank_in;
  logic        host_init_active;
  logic [17:0] draw_addr;
  logic [15:0] draw_data, disp_addr;
  logic [7:0]  host_data;
  logic [2:0]  host_pal_sel_n, pal_wr_n;
  logic [3:0]  bank_write_strobes_n, bank_xcvr_en_n;
  logic [3:0]  colour_table_addr, palette_data, pix_q;
  logic        palette_write_red_n, palette_write_green_n;
  logic        palette_write_blue_n, dac_strobe, dac_blank;
  logic        dac_white, dac_bright, dac_sync, table_init_done;
  int          bad_count = 0;
  int          total_checks = 0;
  assign pal_wr_n = {palette_write_blue_n, palette_write_green_n,
                     palette_write_red_n};
  fbp_pixel_path #(.DEPTH(16)) dut (.clk_sys, .srst, .draw_req, .draw_wr,
    .draw_addr, .draw_data, .disp_rd, .disp_addr, .parallel_load, .blank_in,
    .host_data, .host_pal_sel_n, .host_init_active, .bank_write_strobes_n,
    .bank_xcvr_en_n, .colour_table_addr, .palette_data, .palette_write_red_n,
    .palette_write_green_n, .palette_write_blue_n, .dac_strobe, .dac_blank,
    .dac_white, .dac_bright, .dac_sync, .table_init_done);
  fbp_dac_model dac (.clk_sys, .colour_table_addr, .palette_data, .pal_wr_n,
    .dac_strobe, .pix_q);
  // ****
  // Shared tasks
  // ****
  task automatic chk(input logic [3:0] got, input logic [3:0] exp,
                     input string what);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_palette();
    host_init_active = 1'b1;
    for (int c = 0; c < 3; c++) begin
      host_data = 8'(8'h59 + 8'h11 * c);
      host_pal_sel_n[c] = 1'b0;
      cyc(4);
      chk(colour_table_addr, host_data[7:4], "table addr");
      chk(palette_data, host_data[3:0], "palette data");
      cyc(2);
      host_pal_sel_n[c] = 1'b1;
      cyc(5);
      chk(dac.tbl_q[c][host_data[7:4]], host_data[3:0], "entry");
    end
    host_init_active = 1'b0;
    for (int i = 0; i < 8 && table_init_done !== 1'b1; i++) cyc(1);
    chk({3'h0, table_init_done}, 4'h1, "init done");
    if (table_init_done !== 1'b1) wrap_up();
    // A late write must neither reach the table nor steer the address.
    host_data = 8'h5c;
    host_pal_sel_n[0] = 1'b0;
    cyc(6);
    chk(colour_table_addr, 4'h0, "pixel source");
    host_pal_sel_n[0] = 1'b1;
    cyc(5);
    chk(dac.tbl_q[0][5], 4'h9, "late write");
    $display("palette test done");
  endtask
  task automatic t_draw();
    for (int b = 0; b < 4; b++) begin
      draw_req = 1'b1;
      draw_wr = 1'b1;
      draw_addr = {16'h0003, 2'(b)};
      draw_data = 16'(16'h3210 + 16'h4444 * b);
      cyc(1);
      chk(bank_write_strobes_n, 4'(~(4'h1 << b)), "strobe");
    end
    draw_wr = 1'b0;
    draw_addr = {16'h0003, 2'h2};
    cyc(1);
    chk(bank_xcvr_en_n, 4'hb, "xcvr read");
    chk(bank_write_strobes_n, 4'hf, "no strobe on read");
    draw_req = 1'b0;
    cyc(2);
    $display("draw test done");
  endtask
  task automatic t_stream();
    disp_addr = 16'h0003;
    disp_rd = 1'b1;
    cyc(1);
    disp_rd = 1'b0;
    parallel_load = 1'b1;
    cyc(1);
    parallel_load = 1'b0;
    cyc(2);
    for (int i = 0; i < 16; i++) begin
      chk(pix_q, 4'(i), "pixel");
      cyc(1);
    end
    $display("stream test done");
  endtask
  task automatic t_blank();
    blank_in = 1'b0;
    cyc(3);
    blank_in = 1'b1;
    cyc(1);
    chk({3'h0, dac_blank}, 4'h0, "blank early");
    cyc(1);
    chk({3'h0, dac_blank}, 4'h1, "blank late");
    chk({1'b0, dac_white, dac_bright, dac_sync}, 4'h0, "unused");
    chk({3'h0, dac_strobe}, 4'h1, "strobe");
    $display("blank test done");
  endtask
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end
  initial begin
    {draw_req, draw_wr, disp_rd, parallel_load, blank_in} = 5'h00;
    {host_init_active, draw_addr, draw_data, disp_addr} = 51'h0;
    host_data = 8'h00;
    host_pal_sel_n = 3'h7;
    cyc(8);
    chk(bank_write_strobes_n & bank_xcvr_en_n, 4'hf, "reset strobes");
    chk({3'h0, table_init_done}, 4'h0, "reset done");
    srst = 1'b0;
    cyc(3);
    t_palette();
    t_draw();
    t_stream();
    t_blank();
    wrap_up();
  end
endmodule
`default_nettype wire
